// ---- scm_map.vh ----
// Register map, field positions, reset values and mode codes of the serial clock/mode unit.
// Assumes a 32-bit AHB-Lite slave with word-aligned registers.
`ifndef SCM_MAP_VH
`define SCM_MAP_VH

// Byte offsets
`define SCM_OFF_CLK_EN       8'h00
`define SCM_OFF_PRESCALE     8'h04
`define SCM_OFF_MODE_CFG     8'h08
`define SCM_OFF_STATUS       8'h0C
`define SCM_OFF_START        8'h10

// Reset values
`define SCM_RST_CLK_EN       8'h00
`define SCM_RST_PRESCALE     16'h0000
`define SCM_RST_MODE_CFG     16'h0020

// Writable bit masks and fixed-one bits
`define SCM_MASK_CLK_EN      8'hB5
`define SCM_MASK_PRESCALE    16'h00FF
`define SCM_MASK_MODE_CFG    16'hC147
`define SCM_FIXED_MODE_CFG   16'h0020

// Field positions
`define SCM_BIT_UNIT_ON      2
`define SCM_BIT_CKS          15
`define SCM_BIT_CCS          14
`define SCM_BIT_STS          8
`define SCM_BIT_SIS          6
`define SCM_BIT_MD_HI        2
`define SCM_BIT_MD_LO        1
`define SCM_BIT_INTSEL       0

// Channel function codes
`define SCM_FN_CSI           2'b00
`define SCM_FN_UART          2'b01
`define SCM_FN_I2C           2'b10
`define SCM_FN_BAD           2'b11

// Transfer-clock divider of operating clock (half period, in operating ticks)
`define SCM_TRANSFER_CLOCK_HALF        8'h01

// Prescaler counter width
`define SCM_PS_W             15

`endif

// ---- scm_unit.v ----
// Clock gating, two prescalers and channel mode selection for one serial channel.
// Assumes one 100 MHz clock, AHB-Lite register access and asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
`include "scm_map.vh"

module scm_unit (
	input  wire        ref_clk_i,     // System clock, 100 MHz
	input  wire        nrst_i,        // Asynchronous reset, active low
	input  wire        hsel_i,        // AHB slave select
	input  wire [7:0]  haddr_i,       // AHB address
	input  wire [1:0]  htrans_i,      // AHB transfer type
	input  wire        hwrite_i,      // AHB write
	input  wire [2:0]  hsize_i,       // AHB size
	input  wire        hready_i,      // AHB bus ready
	input  wire [31:0] hwdata_i,      // AHB write data
	output reg  [31:0] hrdata_o,      // AHB read data
	output reg         hreadyout_o,   // AHB slave ready
	output reg         hresp_o,       // AHB response, always OKAY
	input  wire        sck_pin_i,     // External serial clock pin
	input  wire        rxd_pin_i,     // Receive data pin
	output reg         unit_clk_en_o, // Unit clock supply active
	output reg         op_tick_o,     // Channel operating-clock enable pulse
	output reg         transfer_clock_tick_o,   // Transfer-clock enable pulse
	output reg  [1:0]  chan_mode_o,   // Active function code
	output reg         irq_on_empty_o,// Interrupt cause: buffer empty
	output reg         chan_start_o   // Channel start pulse
);

	reg  [7:0]  peripheral_clock_enable_q;
	reg  [15:0] serial_prescaler_select_q;
	reg  [15:0] channel_mode_config_q;
	reg         wr_pend_q;
	reg  [7:0]  wr_addr_q;
	reg  [`SCM_PS_W-1:0] ps_cnt_q;
	reg  [`SCM_PS_W-1:0] ps_prev_q;
	reg         sck_s1_q, sck_s2_q, sck_s3_q;
	reg         rxd_s1_q, rxd_s2_q, rxd_s3_q;
	reg  [7:0]  tdiv_q;
	reg         sw_start_q;
	reg         bad_mode_q;

	wire        unit_clock_supply_on = peripheral_clock_enable_q[`SCM_BIT_UNIT_ON];
	wire [3:0]  sel_a = serial_prescaler_select_q[3:0];
	wire [3:0]  sel_b = serial_prescaler_select_q[7:4];
	wire        operating_clock_source_sel = channel_mode_config_q[`SCM_BIT_CKS];
	wire        transfer_clock_source_sel  = channel_mode_config_q[`SCM_BIT_CCS];
	wire        start_trigger_sel = channel_mode_config_q[`SCM_BIT_STS];
	wire        rx_level_invert   = channel_mode_config_q[`SCM_BIT_SIS];
	wire        channel_function_hi = channel_mode_config_q[`SCM_BIT_MD_HI];
	wire        channel_function_lo = channel_mode_config_q[`SCM_BIT_MD_LO];
	wire        interrupt_cause_sel = channel_mode_config_q[`SCM_BIT_INTSEL];
	wire [1:0]  fn_code = {channel_function_hi, channel_function_lo};

	// Tick of a ripple prescaler tap: sel 0 is every cycle, else bit sel-1 falls
	function tap_tick;
		input [3:0]            sel;
		input [`SCM_PS_W-1:0]  cur;
		input [`SCM_PS_W-1:0]  prv;
		begin
			if (sel == 4'h0) begin
				tap_tick = 1'b1;
			end else begin
				tap_tick = prv[sel-4'h1] & ~cur[sel-4'h1];
			end
		end
	endfunction

	wire prescaler_output_a = unit_clock_supply_on & tap_tick(sel_a, ps_cnt_q, ps_prev_q);
	wire prescaler_output_b = unit_clock_supply_on & tap_tick(sel_b, ps_cnt_q, ps_prev_q);
	wire op_tick = operating_clock_source_sel ? prescaler_output_b : prescaler_output_a;

	wire sck_rise = sck_s2_q & ~sck_s3_q;
	wire div_tick = op_tick & (tdiv_q == `SCM_TRANSFER_CLOCK_HALF);
	wire transfer_clock = transfer_clock_source_sel ? (unit_clock_supply_on & sck_rise)
		: div_tick;

	// Start-bit edge on the receive pin, polarity chosen by level inversion in UART mode, falling edge in other modes
	wire rx_fall = rxd_s3_q & ~rxd_s2_q;
	wire rx_rise = ~rxd_s3_q & rxd_s2_q;
	wire rx_edge = (fn_code == `SCM_FN_UART) ? (rx_level_invert ? rx_rise : rx_fall)
		: rx_fall;
	wire start_now = start_trigger_sel ? (sw_start_q | rx_edge) : sw_start_q;

	// AHB address phase
	wire        ahb_go = hsel_i & hready_i & htrans_i[1];
	wire        ahb_wr = ahb_go & hwrite_i;

	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_pend_q   <= 1'b0;
			wr_addr_q   <= 8'h00;
			hrdata_o    <= 32'h0000_0000;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end else begin
			wr_pend_q <= ahb_wr;
			if (ahb_go) begin
				wr_addr_q <= haddr_i;
			end
			if (ahb_go & ~hwrite_i) begin
				case (haddr_i)
				`SCM_OFF_CLK_EN:   hrdata_o <= {24'h00_0000, peripheral_clock_enable_q};
				`SCM_OFF_PRESCALE: hrdata_o <= {16'h0000, serial_prescaler_select_q};
				`SCM_OFF_MODE_CFG: hrdata_o <= {16'h0000, channel_mode_config_q};
				`SCM_OFF_STATUS:   hrdata_o <= {28'h000_0000, bad_mode_q,
					unit_clock_supply_on, fn_code};
				default:           hrdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Register writes, data phase
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			peripheral_clock_enable_q <= `SCM_RST_CLK_EN;
			serial_prescaler_select_q <= `SCM_RST_PRESCALE;
			channel_mode_config_q     <= `SCM_RST_MODE_CFG;
			sw_start_q                <= 1'b0;
		end else begin
			sw_start_q <= 1'b0;
			if (wr_pend_q) begin
				case (wr_addr_q)
				`SCM_OFF_CLK_EN:
					peripheral_clock_enable_q <= hwdata_i[7:0] & `SCM_MASK_CLK_EN;
				`SCM_OFF_PRESCALE:
					serial_prescaler_select_q <= hwdata_i[15:0] & `SCM_MASK_PRESCALE;
				`SCM_OFF_MODE_CFG:
					channel_mode_config_q <= (hwdata_i[15:0] & `SCM_MASK_MODE_CFG)
						| `SCM_FIXED_MODE_CFG;
				`SCM_OFF_START:
					sw_start_q <= hwdata_i[0];
				default:
					sw_start_q <= 1'b0;
				endcase
			end
		end
	end

	// Prescaler counter runs only with the unit clock supplied
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ps_cnt_q  <= {`SCM_PS_W{1'b0}};
			ps_prev_q <= {`SCM_PS_W{1'b0}};
			tdiv_q    <= 8'h00;
		end else if (unit_clock_supply_on) begin
			ps_cnt_q  <= ps_cnt_q + {{(`SCM_PS_W-1){1'b0}}, 1'b1};
			ps_prev_q <= ps_cnt_q;
			if (op_tick) begin
				tdiv_q <= div_tick ? 8'h00 : tdiv_q + 8'h01;
			end
		end else begin
			ps_cnt_q  <= {`SCM_PS_W{1'b0}};
			ps_prev_q <= {`SCM_PS_W{1'b0}};
			tdiv_q    <= 8'h00;
		end
	end

	// Pin synchronisers
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sck_s1_q <= 1'b0;
			sck_s2_q <= 1'b0;
			sck_s3_q <= 1'b0;
			rxd_s1_q <= 1'b1;
			rxd_s2_q <= 1'b1;
			rxd_s3_q <= 1'b1;
		end else begin
			sck_s1_q <= sck_pin_i;
			sck_s2_q <= sck_s1_q;
			sck_s3_q <= sck_s2_q;
			rxd_s1_q <= rxd_pin_i;
			rxd_s2_q <= rxd_s1_q;
			rxd_s3_q <= rxd_s2_q;
		end
	end

	// Channel outputs
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			unit_clk_en_o  <= 1'b0;
			op_tick_o      <= 1'b0;
			transfer_clock_tick_o    <= 1'b0;
			chan_mode_o    <= `SCM_FN_CSI;
			irq_on_empty_o <= 1'b0;
			chan_start_o   <= 1'b0;
			bad_mode_q     <= 1'b0;
		end else begin
			unit_clk_en_o  <= unit_clock_supply_on;
			op_tick_o      <= op_tick;
			transfer_clock_tick_o    <= transfer_clock;
			irq_on_empty_o <= interrupt_cause_sel;
			chan_start_o   <= unit_clock_supply_on & start_now;
			case (fn_code)
			`SCM_FN_CSI, `SCM_FN_UART, `SCM_FN_I2C: begin
				chan_mode_o <= fn_code;
				bad_mode_q  <= 1'b0;
			end
			default: begin
				bad_mode_q <= 1'b1;
			end
			endcase
		end
	end

endmodule
`default_nettype wire

// ---- scm_unit_properties.sv ----
// Port checker for the serial clock/mode unit.
// Assumes zero-wait AHB-Lite access and registered outputs.
`timescale 1ns/1ps
`default_nettype none
module scm_unit_properties (
	input wire logic        ref_clk_i, nrst_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o,
	input wire logic        unit_clk_en_o, op_tick_o, transfer_clock_tick_o, irq_on_empty_o, chan_start_o,
	input wire logic [7:0]  haddr_i,
	input wire logic [1:0]  htrans_i, chan_mode_o,
	input wire logic [31:0] hwdata_i
);
	logic        wr_q;
	logic [7:0]  a_q;
	logic [31:0] d_q;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	// Write data phase tracking
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_q <= 1'b0;
			a_q <= 8'h00;
			d_q <= 32'h0000_0000;
		end else begin
			wr_q <= hsel_i & hready_i & htrans_i[1] & hwrite_i;
			a_q <= haddr_i;
			if (wr_q)
				d_q <= hwdata_i;
		end
	end
	chk_bus_okay: assert property (hreadyout_o && !hresp_o)
		else $error("bus not ready or not okay");
	chk_gate_ticks: assert property (!unit_clk_en_o [*4] |-> !op_tick_o && !transfer_clock_tick_o)
		else $error("tick while unit clock stopped");
	chk_unit_follow: assert property (wr_q && a_q == 8'h00 |=> ##[0:1] unit_clk_en_o == d_q[2])
		else $error("unit clock enable not following write");
	chk_irq_follow: assert property (wr_q && a_q == 8'h08 |=> ##[0:1] irq_on_empty_o == d_q[0])
		else $error("interrupt cause not following write");
	chk_mode_follow: assert property (wr_q && a_q == 8'h08 && hwdata_i[2:1] != 2'b11
		|=> ##[0:1] chan_mode_o == d_q[2:1]) else $error("function not following write");
	chk_mode_hold: assert property (wr_q && a_q == 8'h08 && hwdata_i[2:1] == 2'b11
		|=> $stable(chan_mode_o) [*3]) else $error("function changed on bad code");
	chk_mode_legal: assert property (chan_mode_o != 2'b11)
		else $error("bad function code active");
	chk_start_pulse: assert property (chan_start_o |=> !chan_start_o)
		else $error("start pulse longer than one cycle");
	cover property (op_tick_o && unit_clk_en_o);
	cover property (transfer_clock_tick_o);
	cover property (chan_start_o);
endmodule
bind scm_unit scm_unit_properties scm_unit_properties_i (.*);
`default_nettype wire

// ---- scm_unit_tb_top.sv ----
// Self-checking bench for the serial clock/mode unit.
// Assumes a zero-wait AHB-Lite slave and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module scm_unit_tb_top;
	logic        ref_clk_i = 1'b0, nrst_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
	logic        sck_pin_i = 1'b0, rxd_pin_i = 1'b1, sck_run = 1'b0;
	logic [7:0]  haddr_i = 8'h00;
	logic [1:0]  htrans_i = 2'b00, cyc = 2'b00;
	logic [2:0]  hsize_i = 3'b010;
	logic [31:0] hwdata_i = 32'h0000_0000, r;
	wire logic   hready_i, hreadyout_o, hresp_o, unit_clk_en_o, op_tick_o, transfer_clock_tick_o;
	wire logic   irq_on_empty_o, chan_start_o;
	wire logic [1:0]  chan_mode_o;
	wire logic [31:0] hrdata_o;
	int          miscompares = 0, checks = 0, nop = 0, ntk = 0, nst = 0, o, t, s;
	// Rows: mode cfg, prescale, op ticks, transfer_clock ticks, function, {bad, on} per 64 cycles
	logic [43:0] rows [5] = '{44'h000_2304_0205, 44'h800_1300_8041, 44'h400_4F21_0089,
		44'h800_6162_010B, 44'h000_3150_2015};
	assign hready_i = hreadyout_o;
	scm_unit scm_unit_i (.*);
	always #5 ref_clk_i = ~ref_clk_i;
	always @(negedge ref_clk_i) begin
		nop += (op_tick_o === 1'b1);
		ntk += (transfer_clock_tick_o === 1'b1);
		nst += (chan_start_o === 1'b1);
	end
	// External serial clock, period 8 cycles
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 2'd1;
		if (sck_run && cyc == 2'd3)
			sck_pin_i <= ~sck_pin_i;
	end
	task automatic test_done(input int hang);
		miscompares += hang;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wait_rdy;
		int n;
		n = 0;
		@(posedge ref_clk_i);
		while (hreadyout_o !== 1'b1) begin
			if (++n > 50)
				test_done(1);
			@(posedge ref_clk_i);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel_i <= 1'b1;
		htrans_i <= 2'b10;
		hwrite_i <= w;
		haddr_i <= a;
		wait_rdy();
		hsel_i <= 1'b0;
		htrans_i <= 2'b00;
		hwdata_i <= d;
		wait_rdy();
		r = hrdata_o;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(r, e);
	endtask
	task automatic win(input int n);
		o = nop;
		t = ntk;
		repeat (n) @(posedge ref_clk_i);
		o = nop - o;
		t = ntk - t;
	endtask
	task automatic rx(input logic v, input int e);
		s = nst;
		rxd_pin_i <= v;
		repeat (8) @(posedge ref_clk_i);
		chk(nst - s, e);
	endtask
	initial begin
		repeat (20) @(posedge ref_clk_i);
		chk(32'(unit_clk_en_o), 32'h0000_0000);
		chk(32'(hreadyout_o), 32'h0000_0001);
		nrst_i <= 1'b1;
		@(posedge ref_clk_i);
		rd(8'h04, 32'h0000_0000);
		rd(8'h08, 32'h0000_0020);
		bus(1'b1, 8'h20, 32'hFFFF_FFFF);
		rd(8'h20, 32'h0000_0000);
		bus(1'b1, 8'h00, 32'h0000_00FF);
		rd(8'h00, 32'h0000_00B5);
		sck_run <= 1'b1;
		foreach (rows[i]) begin
			bus(1'b1, 8'h04, 32'(rows[i][27:20]));
			bus(1'b1, 8'h08, 32'(rows[i][43:28]));
			win(16);
			win(64);
			chk(o, 32'(rows[i][19:12]));
			chk(t, 32'(rows[i][11:4]));
			chk(32'(chan_mode_o), 32'(rows[i][3:2]));
			chk(32'(irq_on_empty_o), 32'(rows[i][28]));
			rd(8'h08, 32'(rows[i][43:28] | 16'h0020));
			bus(1'b0, 8'h0C, 32'h0000_0000);
			chk(32'(r[3:2]), 32'(rows[i][1:0]));
		end
		sck_run <= 1'b0;
		bus(1'b1, 8'h00, 32'h0000_0000);
		win(64);
		chk(o, 32'h0000_0000);
		chk(32'(unit_clk_en_o), 32'h0000_0000);
		bus(1'b1, 8'h00, 32'h0000_0004);
		bus(1'b1, 8'h08, 32'h0000_0102);
		rx(1'b0, 1);
		rx(1'b1, 0);
		bus(1'b1, 8'h08, 32'h0000_0142);
		rx(1'b0, 0);
		rx(1'b1, 1);
		bus(1'b1, 8'h08, 32'h0000_0002);
		rx(1'b0, 0);
		s = nst;
		bus(1'b1, 8'h10, 32'h0000_0001);
		repeat (6) @(posedge ref_clk_i);
		chk(nst - s, 1);
		nrst_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		chk(32'(unit_clk_en_o), 32'h0000_0000);
		nrst_i <= 1'b1;
		@(posedge ref_clk_i);
		rd(8'h08, 32'h0000_0020);
		test_done(0);
	end
endmodule
`default_nettype wire
